// ---- spt_dev.sv ----
`default_nettype none
module spt_dev #(
    parameter int PUW_CYC = spt_pkg::CYC_PUW,
    parameter int WRSR_CYC = spt_pkg::CYC_WRSR
) (
    input wire logic core_clk,
    input wire logic rst_b,
    spt_if.dev link,
    output logic busy,
    output logic mode3,
    output logic deep_pd,
    output logic ultra_pd,
    output logic [7:0] last_op
);
    // Pin synchronisers
    logic [1:0] sck_s_r, cs_s_r, mosi_s_r;
    logic sck_d_r, cs_d_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            mosi_s_r <= 2'h0;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sck_s_r <= {sck_s_r[0], link.sck};
            cs_s_r <= {cs_s_r[0], link.chip_select_n};
            mosi_s_r <= {mosi_s_r[0], link.mosi};
            sck_d_r <= sck_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end
    wire sck_i = sck_s_r[1];
    wire cs_i = cs_s_r[1];
    wire cs_fall = cs_d_r && !cs_i;
    wire cs_rise = !cs_d_r && cs_i;
    wire sck_rise = !sck_d_r && sck_i;
    wire sck_fall = sck_d_r && !sck_i;

    spt_pkg::spt_state_t st_r, st_nxt;
    logic [spt_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, op_r, stat_r;
    logic [3:0] bits_r;
    logic armed_r, mode3_r, oe_r, do_r, rd_r;
    logic [2:0] obit_r;

    // Decoded command at select rise
    wire op_done = cs_rise && bits_r == 4'h8;
    wire idle = st_r == spt_pkg::SPT_STBY;
    wire [spt_pkg::CNT_W-1:0] otp_c = spt_pkg::CNT_W'(spt_pkg::CYC_OTPP);
    // Pin sync and output register delay, taken off the entry counts and the deep power-down resume count
    localparam int SYNC_LAT = 6;

    // Power-state sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        case (st_r)
            spt_pkg::SPT_POR: begin
                st_nxt = spt_pkg::SPT_PUW;
                cnt_nxt = spt_pkg::CNT_W'(PUW_CYC);
            end
            spt_pkg::SPT_PUW: if (cnt_r == '0) st_nxt = spt_pkg::SPT_STBY; // R7
            spt_pkg::SPT_STBY: if (op_done) begin
                if (op_r == spt_pkg::OP_DPD) begin
                    st_nxt = spt_pkg::SPT_BUSY;
                    cnt_nxt = spt_pkg::CNT_W'(spt_pkg::CYC_EDPD - SYNC_LAT); // R8
                end else if (op_r == spt_pkg::OP_UDPD) begin
                    st_nxt = spt_pkg::SPT_BUSY;
                    cnt_nxt = spt_pkg::CNT_W'(spt_pkg::CYC_EUDPD - SYNC_LAT); // R9
                end else if (op_r == spt_pkg::OP_WRSR) begin
                    st_nxt = spt_pkg::SPT_BUSY;
                    cnt_nxt = spt_pkg::CNT_W'(WRSR_CYC); // R12
                end else if (op_r == spt_pkg::OP_OTPP) begin
                    st_nxt = spt_pkg::SPT_BUSY;
                    cnt_nxt = otp_c; // R13
                end
            end
            spt_pkg::SPT_BUSY: if (cnt_r == '0) begin
                if (op_r == spt_pkg::OP_DPD) st_nxt = spt_pkg::SPT_DPD;
                else if (op_r == spt_pkg::OP_UDPD) st_nxt = spt_pkg::SPT_UDPD;
                else st_nxt = spt_pkg::SPT_STBY;
            end
            spt_pkg::SPT_DPD: if (op_done && op_r == spt_pkg::OP_RDPD) begin
                st_nxt = spt_pkg::SPT_BUSY;
                cnt_nxt = spt_pkg::CNT_W'(spt_pkg::CYC_RDPD - SYNC_LAT); // R11
            end
            spt_pkg::SPT_UDPD: if (!cs_i) begin
                if (cnt_r == spt_pkg::CNT_W'(spt_pkg::CYC_CSLU)) begin
                    st_nxt = spt_pkg::SPT_XUD; // R10
                    cnt_nxt = spt_pkg::CNT_W'(spt_pkg::CYC_XUDPD);
                end else cnt_nxt = cnt_r + 1'b1;
            end else cnt_nxt = '0;
            spt_pkg::SPT_XUD: if (cnt_r == '0) st_nxt = spt_pkg::SPT_STBY; // R10
            default: st_nxt = spt_pkg::SPT_POR;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= spt_pkg::SPT_POR; // R4
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Command shifter, armed only by a select fall
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_r <= 1'b0; // R2
            mode3_r <= 1'b0;
            sh_r <= 8'h00;
            op_r <= 8'h00;
            bits_r <= 4'h0;
        end else if (cs_fall) begin
            armed_r <= st_r != spt_pkg::SPT_POR; // R4
            mode3_r <= sck_i; // R3
            bits_r <= 4'h0;
        end else if (cs_i) begin
            armed_r <= 1'b0;
        end else if (armed_r && sck_rise && bits_r != 4'h8) begin
            sh_r <= {sh_r[6:0], mosi_s_r[1]};
            bits_r <= bits_r + 4'h1;
            if (bits_r == 4'h7) op_r <= {sh_r[6:0], mosi_s_r[1]};
        end
    end

    // Status readout: busy bit, program refused while busy
    wire busy_w = st_r != spt_pkg::SPT_STBY && st_r != spt_pkg::SPT_DPD
        && st_r != spt_pkg::SPT_UDPD; // R14
    // Status readable in standby, in the power-up wait and in the busy state, not during ultra-deep exit
    assign rd_r = armed_r && bits_r == 4'h8 && op_r == spt_pkg::OP_RDSR
        && (idle || st_r == spt_pkg::SPT_BUSY || st_r == spt_pkg::SPT_PUW); // R14
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_r <= 1'b0; // R1
            do_r <= 1'b0;
            obit_r <= 3'h0;
            stat_r <= 8'h00;
        end else begin
            stat_r <= busy_w ? spt_pkg::ST_BUSY : 8'h00;
            if (!rd_r) begin
                oe_r <= 1'b0; // R1
                do_r <= 1'b0;
                obit_r <= 3'h0;
            end else if (sck_fall || !oe_r) begin
                oe_r <= 1'b1;
                do_r <= stat_r[3'h7 - obit_r];
                obit_r <= obit_r + 3'h1;
            end
        end
    end

    // Registered status outputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b1;
            mode3 <= 1'b0;
            deep_pd <= 1'b0;
            ultra_pd <= 1'b0;
            last_op <= 8'h00;
        end else begin
            busy <= busy_w; // R14
            mode3 <= mode3_r;
            deep_pd <= st_r == spt_pkg::SPT_DPD;
            ultra_pd <= st_r == spt_pkg::SPT_UDPD;
            last_op <= op_r;
        end
    end
    assign link.miso_o = do_r;
    assign link.miso_oe = oe_r;
endmodule
`default_nettype wire

// ---- spt_pkg.sv ----
// How it works
// [R1] Data output undriven after power-up or reset
// [R2] First instruction needs a chip-select falling edge
// [R3] Clock idle level at select fall picks mode
// [R4] Commands ignored while power-on reset holds
// [R5] Host waits 70 us before first read
// [R6] Program or erase refused until 3 ms
// [R7] After delay: standby or active per select
// [R8] Deep power-down reached within 2 us
// [R9] Ultra-deep power-down reached within 3 us
// [R10] Ultra-deep exit: 20 ns low, 70 us wait
// [R11] Resume from deep power-down within 8 us
// [R12] Status write busy 20 ms, under 40
// [R13] OTP program busy 400 us, under 950
// [R14] Busy reported during every timed operation
`default_nettype none
package spt_pkg;
    localparam int CLK_MHZ = 25;
    localparam int T_VCSL_US = 70;
    localparam int T_PUW_MS = 3;
    localparam int T_EDPD_US = 2;
    localparam int T_EUDPD_US = 3;
    localparam int T_CSLU_NS = 20;
    localparam int T_XUDPD_US = 70;
    localparam int T_RDPD_US = 8;
    localparam int T_WRSR_MS = 20;
    localparam int T_OTPP_US = 400;
    localparam int CYC_VCSL = T_VCSL_US * CLK_MHZ;
    localparam int CYC_PUW = T_PUW_MS * 1000 * CLK_MHZ;
    localparam int CYC_EDPD = T_EDPD_US * CLK_MHZ;
    localparam int CYC_EUDPD = T_EUDPD_US * CLK_MHZ;
    localparam int CYC_CSLU = (T_CSLU_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_XUDPD = T_XUDPD_US * CLK_MHZ;
    localparam int CYC_RDPD = T_RDPD_US * CLK_MHZ;
    localparam int CYC_WRSR = T_WRSR_MS * 1000 * CLK_MHZ;
    localparam int CYC_OTPP = T_OTPP_US * CLK_MHZ;
    localparam int CNT_W = 20;
    localparam logic [7:0] OP_DPD = 8'hB9;
    localparam logic [7:0] OP_UDPD = 8'h79;
    localparam logic [7:0] OP_RDPD = 8'hAB;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_OTPP = 8'h9B;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] ST_BUSY = 8'h01;
    typedef enum logic [2:0] {
        SPT_POR = 3'h0, SPT_PUW = 3'h1, SPT_STBY = 3'h3, SPT_BUSY = 3'h2,
        SPT_DPD = 3'h6, SPT_UDPD = 3'h7, SPT_XUD = 3'h5
    } spt_state_t;
endpackage
`default_nettype wire

// ---- spt_if.sv ----
`default_nettype none
interface spt_if;
    logic sck;
    logic chip_select_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    modport dev(input sck, input chip_select_n, input mosi, output miso_o, output miso_oe);
    modport host(output sck, output chip_select_n, output mosi, input miso_o, input miso_oe);
endinterface
`default_nettype wire

// ---- spt_host.sv ----
`default_nettype none
module spt_host #(
    parameter int PUW_CYC = spt_pkg::CYC_PUW,
    parameter int DIV = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    spt_if.host link,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic cmd_mode3,
    output logic cmd_ready,
    output logic [7:0] rsp_data,
    output logic rsp_valid
);
    logic [spt_pkg::CNT_W-1:0] wait_r;
    logic [7:0] sh_r, rx_r, op_r;
    logic [5:0] ph_r;
    localparam logic [5:0] PH_CMD = 6'h10;
    localparam logic [5:0] PH_RD = 6'h20;
    logic [7:0] div_r;
    logic cs_r, sck_r, mo_r, act_r, m3_r, rdv_r;
    logic [1:0] mi_s_r;
    wire tick = div_r == 8'(DIV - 1);
    wire is_pe = cmd_op == spt_pkg::OP_PROG || cmd_op == spt_pkg::OP_WRSR
        || cmd_op == spt_pkg::OP_OTPP;
    wire is_rd = cmd_op == spt_pkg::OP_READ || cmd_op == spt_pkg::OP_RDSR;
    // Startup gate: read after 70 us, program/erase after 3 ms
    wire ok = is_pe ? wait_r >= spt_pkg::CNT_W'(PUW_CYC) // R6
        : !is_rd || wait_r >= spt_pkg::CNT_W'(spt_pkg::CYC_VCSL); // R5
    // Command taken on a divider tick while idle
    wire take = !act_r && cmd_valid && ok && tick;
    wire [5:0] ph_end = rdv_r ? PH_RD : PH_CMD;
    // Clock divider and transfer sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= '0;
            div_r <= 8'h00;
            cs_r <= 1'b1;
            sck_r <= 1'b0;
            mo_r <= 1'b0;
            act_r <= 1'b0;
            m3_r <= 1'b0;
            ph_r <= 6'h00;
            mi_s_r <= 2'h0;
            sh_r <= 8'h00;
            rx_r <= 8'h00;
            op_r <= 8'h00;
            rdv_r <= 1'b0;
            rsp_data <= 8'h00;
            rsp_valid <= 1'b0;
            cmd_ready <= 1'b0;
        end else begin
            mi_s_r <= {mi_s_r[0], link.miso_o};
            rsp_valid <= 1'b0;
            if (wait_r != '1) wait_r <= wait_r + 1'b1;
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            cmd_ready <= !act_r && !take;
            if (!act_r) begin
                sck_r <= cmd_mode3;
                if (take) begin
                    act_r <= 1'b1;
                    cs_r <= 1'b0; // R2
                    m3_r <= cmd_mode3; // R3
                    sh_r <= cmd_op;
                    op_r <= cmd_op;
                    rdv_r <= cmd_op == spt_pkg::OP_RDSR;
                    ph_r <= 6'h00;
                end
            end else if (tick) begin
                ph_r <= ph_r + 6'h01;
                if (ph_r == ph_end) begin
                    cs_r <= 1'b1;
                    act_r <= 1'b0;
                    sck_r <= m3_r;
                    rsp_data <= rx_r;
                    rsp_valid <= 1'b1;
                end else if (!ph_r[0]) begin
                    sck_r <= 1'b0;
                    mo_r <= sh_r[7];
                    sh_r <= {sh_r[6:0], 1'b0};
                end else begin
                    sck_r <= 1'b1;
                    rx_r <= {rx_r[6:0], mi_s_r[1]};
                end
            end
        end
    end
    assign link.sck = sck_r;
    assign link.chip_select_n = cs_r;
    assign link.mosi = mo_r;
endmodule
`default_nettype wire

// ---- spt_asserts.sv ----
`default_nettype none
module spt_asserts (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sck,
    input wire logic chip_select_n,
    input wire logic miso_oe,
    input wire logic busy,
    input wire logic mode3,
    input wire logic deep_pd,
    input wire logic ultra_pd,
    input wire logic [7:0] last_op
);
    localparam int C_EDPD = spt_pkg::CYC_EDPD;
    localparam int C_EUDPD = spt_pkg::CYC_EUDPD;
    localparam int C_RDPD = spt_pkg::CYC_RDPD;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Output and mode relations
    property p_oe_rst; $rose(rst_b) |-> !miso_oe && busy; endproperty
    property p_oe_idle; chip_select_n [*5] |-> !miso_oe; endproperty
    property p_mode3; $fell(chip_select_n) && sck |-> ##[1:4] mode3; endproperty
    property p_mode0; $fell(chip_select_n) && !sck |-> ##[1:4] !mode3; endproperty
    // Power-down entry and exit timing, status write busy
    property p_dpd;
        $rose(chip_select_n) && last_op == spt_pkg::OP_DPD && !busy && !deep_pd && !ultra_pd
            |-> ##[0:C_EDPD] deep_pd;
    endproperty
    property p_udpd;
        $rose(chip_select_n) && last_op == spt_pkg::OP_UDPD && !busy && !deep_pd && !ultra_pd
            |-> ##[0:C_EUDPD] ultra_pd;
    endproperty
    property p_rdpd;
        $rose(chip_select_n) && deep_pd && last_op == spt_pkg::OP_RDPD
            |-> ##[0:C_RDPD] !deep_pd && !busy;
    endproperty
    property p_wrsr;
        $rose(chip_select_n) && last_op == spt_pkg::OP_WRSR && !busy && !deep_pd && !ultra_pd
            |-> ##[1:8] busy;
    endproperty
    property p_uexit; ultra_pd && $fell(chip_select_n) |-> ##[1:8] busy; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("output driven after reset");
    a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
    a_mode3: assert property (p_mode3) else $error("mode 3 not picked");
    a_mode0: assert property (p_mode0) else $error("mode 0 not picked");
    a_dpd: assert property (p_dpd) else $error("deep power-down late");
    a_udpd: assert property (p_udpd) else $error("ultra power-down late");
    a_rdpd: assert property (p_rdpd) else $error("resume late");
    a_wrsr: assert property (p_wrsr) else $error("status write not busy");
    a_uexit: assert property (p_uexit) else $error("ultra exit not busy");
    // Main scenarios reached
    c_mode3: cover property ($fell(chip_select_n) && sck);
    c_dpd: cover property ($rose(deep_pd));
    c_uexit: cover property (ultra_pd && $fell(chip_select_n));
endmodule
`default_nettype wire

// ---- spi_flash_power_state_timing_test.sv ----
`default_nettype none
module spi_flash_power_state_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] op; logic m3; logic [2:0] exp;} spt_row_t;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic cmd_mode3 = 1'b0;
    logic cmd_ready, rsp_valid, busy, mode3, deep_pd, ultra_pd;
    logic [7:0] rsp_data, last_op, seen_rsp;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int t0 = 0;
    // Opcode, idle clock level, expected {mode3, deep, ultra}
    spt_row_t rows [4] = '{'{spt_pkg::OP_RDSR, 1'b0, 3'h0}, '{spt_pkg::OP_DPD, 1'b1, 3'h6},
        '{spt_pkg::OP_RDPD, 1'b0, 3'h0}, '{spt_pkg::OP_UDPD, 1'b1, 3'h5}};

    spt_if u_spt_if ();
    spt_dev #(.PUW_CYC(200), .WRSR_CYC(200)) u_spt_dev (.core_clk(core_clk), .rst_b(rst_b),
        .link(u_spt_if), .busy(busy), .mode3(mode3), .deep_pd(deep_pd), .ultra_pd(ultra_pd),
        .last_op(last_op));
    spt_host #(.PUW_CYC(200), .DIV(4)) u_spt_host (.core_clk(core_clk), .rst_b(rst_b),
        .link(u_spt_if), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_mode3(cmd_mode3),
        .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
    spt_asserts u_spt_asserts (.core_clk(core_clk), .rst_b(rst_b), .sck(u_spt_if.sck),
        .chip_select_n(u_spt_if.chip_select_n), .miso_oe(u_spt_if.miso_oe), .busy(busy),
        .mode3(mode3), .deep_pd(deep_pd), .ultra_pd(ultra_pd), .last_op(last_op));

    // Clock and hang limit
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 15000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("miscompares %0d of tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One command frame, held until taken, response kept
    task automatic send(input logic [7:0] op, input logic m3);
        cmd_op = op;
        cmd_mode3 = m3;
        cmd_valid = 1'b1;
        do idle(1); while (cmd_ready !== 1'b1);
        do idle(1); while (cmd_ready !== 1'b0);
        cmd_valid = 1'b0;
        do idle(1); while (rsp_valid !== 1'b1);
        seen_rsp = rsp_data;
    endtask

    // Main sequence
    initial begin
        idle(8);
        rst_b = 1'b1;
        t0 = cycles;
        for (int i = 0; i < 4; i++) begin
            send(rows[i].op, rows[i].m3);
            if (i == 0) check(8'(cycles - t0 >= spt_pkg::CYC_VCSL), 8'h01);
            if (i == 0) check(seen_rsp, 8'h00);
            idle(210);
            check(8'({mode3, deep_pd, ultra_pd}), 8'(rows[i].exp));
            check(last_op, rows[i].op);
        end
        // Select low wakes ultra power-down, busy for exit time
        send(spt_pkg::OP_RDSR, 1'b0);
        check(8'(busy), 8'h01);
        idle(spt_pkg::CYC_XUDPD);
        send(spt_pkg::OP_RDSR, 1'b0);
        check(8'({seen_rsp[0], ultra_pd}), 8'h00);
        // Status write busy, visible to a status read
        send(spt_pkg::OP_WRSR, 1'b0);
        send(spt_pkg::OP_RDSR, 1'b0);
        check(8'({seen_rsp[0], busy}), 8'h03);
        idle(80);
        check(8'(busy), 8'h00);
        // Mid-run reset releases output and restarts power-up delay
        rst_b = 1'b0;
        idle(2);
        check(8'({busy, u_spt_if.miso_oe}), 8'h02);
        rst_b = 1'b1;
        idle(100);
        check(8'(busy), 8'h01);
        idle(110);
        check(8'({busy, deep_pd, ultra_pd}), 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
